// >>> logic/rwg_cfg_word.sv
// One guarded 32-bit configuration word with byte enables
`timescale 1ns/1ns
`default_nettype none
module rwg_cfg_word
    import rwg_pkg::*;
(
    input  wire logic         core_clk_in,
    input  wire logic         sys_rst_in,
    input  wire logic         wr_in,
    input  wire logic [3:0]   sel_in,
    input  wire logic [31:0]  data_in,
    output logic [31:0]       word_out
);
    typedef struct packed {
        logic [31:0] word;
    } rwg_word_state_type;
    rwg_word_state_type st;
    rwg_word_state_type next_st;

    // Byte lanes update only on an accepted write
    always_comb begin
        next_st = st;
        for (int b = 0; b < 4; b++) begin
            if (wr_in && sel_in[b]) begin
                next_st.word[b*8 +: 8] = data_in[b*8 +: 8];
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            st.word <= RWG_CFG_RESET;
        end else begin
            st <= next_st;
        end
    end
    assign word_out = st.word;
endmodule : rwg_cfg_word
`default_nettype wire

// >>> logic/rwg_mode_decode.sv
// Guard code to mode decoder
`timescale 1ns/1ns
`default_nettype none
module rwg_mode_decode
    import rwg_pkg::*;
(
    input  wire logic [7:0]   code_in,
    output rwg_mode_type      mode_out
);
    // Only two codes unlock; everything else protects
    always_comb begin
        if (code_in == RWG_CODE_FULL) begin
            mode_out = RWG_MODE_FULL;
        end else if (code_in == RWG_CODE_SINGLE) begin
            mode_out = RWG_MODE_SINGLE;
        end else begin
            mode_out = RWG_MODE_PROTECTED;
        end
    end
endmodule : rwg_mode_decode
`default_nettype wire

// >>> logic/rwg_pkg.sv
// Package with register map, guard codes and reset values for the register write guard
// How it works
// - Protected mode ignores writes to every register except the guard and status registers.
// - Guard codes 0x00 through 0x84 mean protected mode.
// - Code 0x85 accepts all writes until the guard code changes.
// - Code 0x86 accepts one write, then the guard returns to protected.
package rwg_pkg;
    localparam logic [7:0] RWG_ADDR_W          = 8'h08;
    localparam logic [7:0] RWG_OFF_GUARD       = 8'h00;
    localparam logic [7:0] RWG_OFF_CFG0        = 8'h04;
    localparam logic [7:0] RWG_OFF_CFG1        = 8'h08;
    localparam logic [7:0] RWG_OFF_CFG2        = 8'h0C;
    localparam logic [7:0] RWG_OFF_CFG3        = 8'h10;
    localparam logic [7:0] RWG_OFF_STATUS      = 8'h14;
    localparam int         RWG_NUM_CFG         = 4;
    localparam logic [7:0] RWG_GUARD_RESET     = 8'h85;
    localparam logic [7:0] RWG_CODE_PROT_MAX   = 8'h84;
    localparam logic [7:0] RWG_CODE_FULL       = 8'h85;
    localparam logic [7:0] RWG_CODE_SINGLE     = 8'h86;
    localparam logic [7:0] RWG_CODE_PROTECT    = 8'h00;
    localparam logic [31:0] RWG_CFG_RESET      = 32'h00000000;
    typedef enum logic [1:0] {
        RWG_MODE_PROTECTED,
        RWG_MODE_FULL,
        RWG_MODE_SINGLE
    } rwg_mode_type;
endpackage : rwg_pkg

// >>> logic/rwg_top.sv
// Register write guard with a Wishbone slave and four guarded configuration words
//
// Added by the designer: the register addresses and the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none
module rwg_top
    import rwg_pkg::*;
(
    input  wire logic         core_clk_in,
    input  wire logic         sys_rst_in,
    input  wire logic         wb_cyc_in,
    input  wire logic         wb_stb_in,
    input  wire logic         wb_we_in,
    input  wire logic [7:0]   wb_adr_in,
    input  wire logic [3:0]   wb_sel_in,
    input  wire logic [31:0]  wb_dat_in,
    output logic [31:0]       wb_dat_out,
    output logic              wb_ack_out,
    output logic              wb_err_out,
    output logic [31:0]       cfg0_out,
    output logic [31:0]       cfg1_out,
    output logic [31:0]       cfg2_out,
    output logic [31:0]       cfg3_out,
    output rwg_mode_type      mode_out
);
    typedef struct packed {
        logic [7:0]  guard;
        logic        ack;
        logic        err;
        logic [31:0] rdata;
        logic        blocked;
        logic [7:0]  blocked_count;
    } rwg_state_type;

    rwg_state_type st;
    rwg_state_type next_st;
    rwg_mode_type  mode;
    logic [31:0]   cfg [RWG_NUM_CFG];
    logic [RWG_NUM_CFG-1:0] cfg_wr;
    logic          req;
    logic          wr_req;
    logic          hit_guard;
    logic          hit_status;
    logic [RWG_NUM_CFG-1:0] hit_cfg;
    logic          mapped;
    logic          cfg_hit_any;
    logic          allow;

    rwg_mode_decode u_decode (
        .code_in  (st.guard),
        .mode_out (mode)
    );

    // New request only while no answer is out, so each access acts once
    assign req    = wb_cyc_in && wb_stb_in && !st.ack && !st.err;
    assign wr_req = req && wb_we_in;

    // Address decode
    assign hit_guard  = (wb_adr_in == RWG_OFF_GUARD);
    assign hit_status = (wb_adr_in == RWG_OFF_STATUS);
    assign hit_cfg[0] = (wb_adr_in == RWG_OFF_CFG0);
    assign hit_cfg[1] = (wb_adr_in == RWG_OFF_CFG1);
    assign hit_cfg[2] = (wb_adr_in == RWG_OFF_CFG2);
    assign hit_cfg[3] = (wb_adr_in == RWG_OFF_CFG3);
    assign cfg_hit_any = |hit_cfg;
    assign mapped      = hit_guard || hit_status || cfg_hit_any;

    // Writes to guarded words pass only in an unlocked mode
    assign allow  = (mode != RWG_MODE_PROTECTED);
    assign cfg_wr = (wr_req && allow) ? hit_cfg : '0;

    generate
        for (genvar i = 0; i < RWG_NUM_CFG; i++) begin : g_cfg
            rwg_cfg_word u_word (
                .core_clk_in (core_clk_in),
                .sys_rst_in  (sys_rst_in),
                .wr_in       (cfg_wr[i]),
                .sel_in      (wb_sel_in),
                .data_in     (wb_dat_in),
                .word_out    (cfg[i])
            );
        end
    endgenerate

    // Bus answer, guard update and single-shot re-arm
    always_comb begin
        next_st     = st;
        next_st.ack = 1'b0;
        next_st.err = 1'b0;
        if (req) begin
            next_st.ack = mapped;
            next_st.err = !mapped;
            next_st.rdata = 32'h00000000;
            if (hit_guard) begin
                next_st.rdata = {24'h000000, st.guard};
            end else if (hit_status) begin
                next_st.rdata = {15'h0000, st.blocked, st.blocked_count, 6'h00, mode};
            end else begin
                for (int i = 0; i < RWG_NUM_CFG; i++) begin
                    if (hit_cfg[i]) begin
                        next_st.rdata = cfg[i];
                    end
                end
            end
        end
        // Single mode closes after one accepted guarded write
        if (wr_req && cfg_hit_any && (mode == RWG_MODE_SINGLE)) begin
            next_st.guard = RWG_CODE_PROTECT;
        end
        // Guard itself writable in every mode; a direct write wins over re-arm
        if (wr_req && hit_guard && wb_sel_in[0]) begin
            next_st.guard = wb_dat_in[7:0];
        end
        // Sticky note of refused writes, cleared by writing status
        if (wr_req && hit_status) begin
            next_st.blocked       = 1'b0;
            next_st.blocked_count = 8'h00;
        end
        if (wr_req && cfg_hit_any && !allow) begin
            next_st.blocked = 1'b1;
            if (st.blocked_count != 8'hFF) begin
                next_st.blocked_count = st.blocked_count + 8'h01;
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            st.guard         <= RWG_GUARD_RESET;
            st.ack           <= 1'b0;
            st.err           <= 1'b0;
            st.rdata         <= 32'h00000000;
            st.blocked       <= 1'b0;
            st.blocked_count <= 8'h00;
        end else begin
            st <= next_st;
        end
    end

    assign wb_ack_out = st.ack;
    assign wb_err_out = st.err;
    assign wb_dat_out = st.rdata;
    assign cfg0_out   = cfg[0];
    assign cfg1_out   = cfg[1];
    assign cfg2_out   = cfg[2];
    assign cfg3_out   = cfg[3];
    assign mode_out   = mode;
endmodule : rwg_top
`default_nettype wire

// >>> test/rwg_top_props.sv
// Concurrent checks on the register write guard ports
`timescale 1ns/1ns
`default_nettype none
module rwg_top_props
    import rwg_pkg::*;
(
    input wire logic         core_clk_in,
    input wire logic         sys_rst_in,
    input wire logic         wb_cyc_in,
    input wire logic         wb_stb_in,
    input wire logic         wb_we_in,
    input wire logic [7:0]   wb_adr_in,
    input wire logic [3:0]   wb_sel_in,
    input wire logic [31:0]  wb_dat_in,
    input wire logic [31:0]  wb_dat_out,
    input wire logic         wb_ack_out,
    input wire logic         wb_err_out,
    input wire logic [31:0]  cfg0_out,
    input wire logic [31:0]  cfg1_out,
    input wire logic [31:0]  cfg2_out,
    input wire logic [31:0]  cfg3_out,
    input wire rwg_mode_type mode_out
);
    // Taken writes; a request held through ack is not taken twice
    wire       tw = wb_cyc_in & wb_stb_in & wb_we_in & !wb_ack_out & !wb_err_out;
    wire       gw = tw & wb_sel_in[0] & (wb_adr_in == RWG_OFF_GUARD);
    wire       cw = tw & (wb_adr_in inside {RWG_OFF_CFG0, RWG_OFF_CFG1, RWG_OFF_CFG2, RWG_OFF_CFG3});
    wire [7:0] gc = wb_dat_in[7:0];
    wire       pm = mode_out == RWG_MODE_PROTECTED;
    wire       fm = mode_out == RWG_MODE_FULL;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);
    chk_prot_block: assert property (tw && wb_adr_in == RWG_OFF_CFG0 && pm |=> $stable(cfg0_out))
        else $error("blocked write changed cfg0");
    chk_low_codes: assert property (gw && gc <= RWG_CODE_PROT_MAX |=> pm)
        else $error("low code not protected");
    chk_full_code: assert property (gw && gc == RWG_CODE_FULL |=> fm)
        else $error("full code not unprotected");
    chk_full_hold: assert property (fm && !gw |=> fm)
        else $error("full mode left without guard write");
    chk_full_write: assert property (tw && fm && wb_adr_in == RWG_OFF_CFG1 && wb_sel_in == 4'hF
        |=> cfg1_out == $past(wb_dat_in)) else $error("full mode write lost");
    chk_single_code: assert property (gw && gc == RWG_CODE_SINGLE |=> mode_out == RWG_MODE_SINGLE)
        else $error("single code not decoded");
    chk_single_rearm: assert property (mode_out == RWG_MODE_SINGLE && cw |=> pm)
        else $error("single mode did not re-arm");
    chk_high_codes: assert property (gw && gc > RWG_CODE_SINGLE |=> pm)
        else $error("high code not protected");
    chk_single_stays: assert property (mode_out == RWG_MODE_SINGLE && !cw && !gw |=> mode_out == RWG_MODE_SINGLE)
        else $error("single mode closed without a write");
endmodule : rwg_top_props
bind rwg_top rwg_top_props i_props (.core_clk_in, .sys_rst_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in,
    .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out, .wb_err_out, .cfg0_out, .cfg1_out, .cfg2_out, .cfg3_out,
    .mode_out);
`default_nettype wire

// >>> test/tb_register_write_guard.sv
// Self-checking bench for the register write guard
`timescale 1ns/1ns
`default_nettype none
module tb_register_write_guard
    import rwg_pkg::*;
;
    logic core_clk_in = 1'b0, sys_rst_in = 1'b1, wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0;
    logic [7:0] wb_adr_in = 8'h00;
    logic [3:0] wb_sel_in = 4'h0;
    logic [31:0] wb_dat_in = 32'h0, wb_dat_out, cfg0_out, cfg1_out, cfg2_out, cfg3_out, rd_data;
    logic wb_ack_out, wb_err_out, got_err;
    rwg_mode_type mode_out;
    logic [7:0] pc [4] = '{8'h00, 8'h84, 8'h87, 8'hFF};
    int miscompares = 0, compares = 0, cycles = 0;
    // 125 MHz clock
    always #4 core_clk_in = ~core_clk_in;
    rwg_top i_dut (.core_clk_in, .sys_rst_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in,
        .wb_dat_in, .wb_dat_out, .wb_ack_out, .wb_err_out, .cfg0_out, .cfg1_out, .cfg2_out, .cfg3_out, .mode_out);
    // Classic cycle held until ack or err is sampled, then one idle cycle
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        wb_cyc_in <= 1'b1;
        wb_stb_in <= 1'b1;
        wb_we_in <= w;
        wb_adr_in <= a;
        wb_sel_in <= 4'hF;
        wb_dat_in <= d;
        do @(posedge core_clk_in); while (wb_ack_out !== 1'b1 && wb_err_out !== 1'b1);
        rd_data = wb_dat_out;
        got_err = wb_err_out;
        wb_cyc_in <= 1'b0;
        wb_stb_in <= 1'b0;
        @(posedge core_clk_in);
    endtask : bus
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic test_done();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : test_done
    // Hang guard; the sequence needs under 200 cycles
    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles > 1000) begin
            miscompares++;
            test_done();
        end
    end
    // Main sequence
    initial begin
        repeat (2) @(posedge core_clk_in);
        sys_rst_in <= 1'b0;
        bus(1'b0, RWG_OFF_GUARD, 32'h0);
        chk("guard", rd_data, 32'(RWG_GUARD_RESET));
        bus(1'b1, RWG_OFF_CFG1, 32'hA5A51234);
        bus(1'b1, RWG_OFF_CFG0, 32'hC3);
        chk("cfg1", cfg1_out, 32'hA5A51234);
        chk("mode", 32'(mode_out), 32'(RWG_MODE_FULL));
        $display("test reset_full done");
        // Every protected code band, guard stays writable and readable
        foreach (pc[i]) begin
            bus(1'b1, RWG_OFF_GUARD, {24'h0, pc[i]});
            bus(1'b1, RWG_OFF_CFG0, 32'hFFFFFFFF);
            chk("mode", 32'(mode_out), 32'(RWG_MODE_PROTECTED));
            chk("cfg0", cfg0_out, 32'hC3);
            bus(1'b0, RWG_OFF_GUARD, 32'h0);
            chk("guard", rd_data, {24'h0, pc[i]});
        end
        // Four refused writes counted, flag set, mode still protected
        bus(1'b0, RWG_OFF_STATUS, 32'h0);
        chk("status", rd_data, 32'h00010400);
        bus(1'b0, RWG_OFF_CFG0, 32'h0);
        chk("cfg0 read", rd_data, 32'hC3);
        bus(1'b1, RWG_OFF_STATUS, 32'h0);
        bus(1'b0, RWG_OFF_STATUS, 32'h0);
        chk("status clear", rd_data, 32'h00000000);
        $display("test protected done");
        // Unlock once before the write, as software must
        bus(1'b1, RWG_OFF_GUARD, 32'h86);
        chk("mode", 32'(mode_out), 32'(RWG_MODE_SINGLE));
        bus(1'b1, RWG_OFF_CFG0, 32'h11);
        chk("cfg0", cfg0_out, 32'h11);
        chk("mode", 32'(mode_out), 32'(RWG_MODE_PROTECTED));
        bus(1'b1, RWG_OFF_CFG0, 32'h22);
        chk("cfg0", cfg0_out, 32'h11);
        $display("test single done");
        bus(1'b1, RWG_OFF_GUARD, 32'h85);
        bus(1'b1, RWG_OFF_CFG0, 32'h33);
        bus(1'b1, RWG_OFF_CFG0, 32'h44);
        chk("cfg0", cfg0_out, 32'h44);
        bus(1'b0, 8'h40, 32'h0);
        chk("err", 32'(got_err), 32'h1);
        $display("test full_unmapped done");
        test_done();
    end
endmodule : tb_register_write_guard
`default_nettype wire
